// ### core/bmesc_pkg.sv
/*
  Shared constants, field layouts and types of the step-down converter mode, enable and
  start-up controller.
  Assumes a single 125 MHz clock and a 32-bit classic Wishbone register bus.
*/
package bmesc_pkg;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int          CLK_PERIOD_NS  = 8;
  localparam int          CLK_FREQ_KHZ   = 125000;
  localparam int          REF_TIME_NS    = 5000;
  localparam int          REF_CYC        = (REF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          STRAP_TIME_NS  = 32;
  localparam int          STRAP_CYC      = (STRAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          EN_DELAY_NS    = 10000;
  localparam int          EN_DELAY_CYC   = (EN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RAMP_TIME_US   = 1000;
  localparam int          RAMP_CYC       = (RAMP_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS;
  localparam int          SYNC_GAP_NS    = 1000;
  localparam logic [7:0]  SYNC_GAP_CYC   = 8'(SYNC_GAP_NS / CLK_PERIOD_NS);
  localparam logic [2:0]  NONSYNC_CYCLES = 3'h6;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Switching frequencies and divider periods
  localparam int          FSW_A_KHZ      = 1500;
  localparam int          FSW_B_KHZ      = 2250;
  localparam int          FSW_C_KHZ      = 2500;
  localparam int          FSW_D_KHZ      = 3000;
  localparam logic [7:0]  PER_A          = 8'(CLK_FREQ_KHZ / FSW_A_KHZ);
  localparam logic [7:0]  PER_B          = 8'(CLK_FREQ_KHZ / FSW_B_KHZ);
  localparam logic [7:0]  PER_C          = 8'(CLK_FREQ_KHZ / FSW_C_KHZ);
  localparam logic [7:0]  PER_D          = 8'(CLK_FREQ_KHZ / FSW_D_KHZ);
  localparam logic [7:0]  PER_RST        = PER_B;

  // Strap pin codes: MSB is the plain level, LSB the level under the test current
  localparam logic [1:0]  STRAP_GND      = 2'h0;
  localparam logic [1:0]  STRAP_RES_GND  = 2'h1;
  localparam logic [1:0]  STRAP_RES_VIN  = 2'h2;
  localparam logic [1:0]  STRAP_VIN      = 2'h3;

  // Load classification codes
  localparam logic [1:0]  LOAD_VERY_LOW  = 2'h0;
  localparam logic [1:0]  LOAD_LOW       = 2'h1;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0]  ADR_CTRL_A     = 8'h00;
  localparam logic [7:0]  ADR_CTRL_C     = 8'h04;
  localparam logic [7:0]  ADR_STATUS     = 8'h08;
  localparam int          CA_FORCED_PULSE_WIDTH_OPERATION_BIT    = 0;
  localparam int          CA_NONSYNC_BIT = 1;
  localparam int          CC_SINGLE_BIT  = 0;
  localparam logic        CA_FORCED_PULSE_WIDTH_OPERATION_RST    = 1'b0;
  localparam logic        CA_NONSYNC_RST = 1'b0;
  localparam logic        CC_SINGLE_RST  = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    FS_LOCKOUT, FS_REF, FS_STRAP, FS_LOAD, FS_IDLE, FS_DELAY, FS_RAMP, FS_RUN
  } bmesc_fsm_type;

  typedef enum logic [1:0] {
    OP_OFF, OP_CCM, OP_DCM, OP_PFM
  } bmesc_op_type;

  typedef struct packed {
    logic       mode_pin;
    logic       en_pin;
    logic       input_undervoltage_lockout;
    logic       thermal_fault;
    logic       overvoltage_fault;
    logic       load_release;
    logic       zero_cross;
    logic       pfm_demand;
    logic [1:0] load_level;
    logic [1:0] voltage_strap_pin;
    logic [1:0] frequency_strap_pin;
    logic       sync_out_strap;
  } bmesc_pins_type;

  typedef struct packed {
    logic [15:0]  reserved;
    logic [3:0]   fsm;
    bmesc_op_type op;
    logic [1:0]   fstrap;
    logic [1:0]   vstrap;
    logic         sout;
    logic         nonsync_active;
    logic         sync_present;
    logic         power_save;
    logic         fault;
    logic         init_done;
  } bmesc_status_type;

endpackage : bmesc_pkg

// ### core/bmesc_sync.sv
/*
  Two-flop synchroniser for a vector of asynchronous pin levels.
  Assumes each bit is an independent level; no word coherence across bits.
*/
`timescale 1ns/10ps
module bmesc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  import bmesc_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } bmesc_sync_state_type;

  bmesc_sync_state_type q;
  bmesc_sync_state_type n;

  always_comb begin
    n      = q;
    n.meta = d_i;
    n.held = q.meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign q_o = q.held;

endmodule : bmesc_sync

// ### core/bmesc_div.sv
/*
  Switching-cycle divider: one-cycle tick every period_i clocks while run_i is high.
  Assumes period_i is at least 2 and stable while running.
*/
`timescale 1ns/10ps
module bmesc_div #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             run_i,
  input  wire logic [WIDTH-1:0] period_i,
  output logic                  tick_o
);
  import bmesc_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             tick;
  } bmesc_div_state_type;

  bmesc_div_state_type q;
  bmesc_div_state_type n;

  always_comb begin
    n      = q;
    n.tick = 1'b0;
    if (!run_i) begin
      n.cnt = '0;
    end else if (q.cnt == period_i - WIDTH'(1)) begin
      n.cnt  = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = q.cnt + WIDTH'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tick_o = q.tick;

endmodule : bmesc_div

// ### core/bmesc_top.sv
/*
  Mode selection, enable-line handling and power-up sequencing of a step-down converter,
  with a classic Wishbone register slave.
  Assumes pins arrive asynchronously, the enable pin is open drain with an external pull-up,
  and the analog loop classifies load and reports zero crossing and pulse demand.
*/
`timescale 1ns/10ps

// Operation
// - Power save with mode pin low, forced bit clear and no sync clock present, and always during the ramp; else forced PWM
// - Forced PWM always uses continuous fixed-frequency conduction
// - Power save picks continuous, discontinuous or pulse skip by load level
// - Discontinuous mode keeps the switching frequency, pulses every cycle
// - Pulse skip pulses only on demand, aligned to the switching tick
// - Load release keeps low-side switch off for six switching cycles
// - Enable pin is input and open-drain ready or fault output
// - Enable pulled low from power-up until defaults and straps are loaded
// - Faults pull enable low unless standalone bit is set
// - Standalone set: no fault pulldown, initialization pulldown remains
// - Shared line low from any peer blocks start and stops the converter
// - After init without fault, release enable and follow its level
// - Register interface opens at init completion, independent of enable
// - Enable low keeps both switches off and control idle
// - Lockout clear: pull enable, start reference, read straps, load defaults
// - Enable low after init: registers accessible, converter idle
// - Enable high after init: registers accessible, ramp after short delay
// - Start-up ramp permits discontinuous and pulse-skip operation
module bmesc_top #(
  parameter int RAMP_CYCLES = bmesc_pkg::RAMP_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  input  wire bmesc_pkg::bmesc_pins_type pins_i,
  output logic                           en_pin_o,
  output logic                           en_pin_oe,
  output logic                           hs_gate_o,
  output logic                           ls_gate_o,
  output bmesc_pkg::bmesc_op_type        op_mode_o,
  output logic                           reg_if_en_o,
  output logic                           ramp_o
);
  import bmesc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    bmesc_fsm_type fsm;
    logic [23:0]   timer;
    logic          init_done;
    logic          pull;
    logic          forced_pwm_select_bit;
    logic          nonsync_en;
    logic          standalone;
    logic [1:0]    vstrap;
    logic [1:0]    fstrap;
    logic          sout;
    logic [7:0]    period;
    logic          mode_d;
    logic [7:0]    gap;
    logic          sync_pres;
    logic          rel_d;
    logic [2:0]    ns_cnt;
    bmesc_op_type  op;
    logic          hs;
    logic          ls;
    logic          ack;
    logic [31:0]   rdat;
  } bmesc_state_type;

  localparam bmesc_state_type STATE_RST = '{
    fsm:                   FS_LOCKOUT,
    timer:                 24'h00_0000,
    init_done:             1'b0,
    pull:                  1'b1,
    forced_pwm_select_bit: CA_FORCED_PULSE_WIDTH_OPERATION_RST,
    nonsync_en:            CA_NONSYNC_RST,
    standalone:            CC_SINGLE_RST,
    vstrap:                2'h0,
    fstrap:                2'h0,
    sout:                  1'b0,
    period:                PER_RST,
    mode_d:                1'b0,
    gap:                   SYNC_GAP_CYC,
    sync_pres:             1'b0,
    rel_d:                 1'b0,
    ns_cnt:                3'h0,
    op:                    OP_OFF,
    hs:                    1'b0,
    ls:                    1'b0,
    ack:                   1'b0,
    rdat:                  32'h0000_0000
  };

  bmesc_state_type                  q;
  bmesc_state_type                  n;
  logic [$bits(bmesc_pins_type)-1:0] pins_raw;
  bmesc_pins_type                   s;
  logic                             sw_tick;
  logic                             running;
  logic                             fault;
  logic                             en_ok;
  logic                             forced;
  logic                             power_save;
  logic                             req;
  bmesc_status_type                 status;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and switching-cycle divider
  bmesc_sync #(
    .WIDTH ($bits(bmesc_pins_type))
  ) u_sync (
    .clk   (clk),
    .rst   (rst),
    .d_i   (pins_i),
    .q_o   (pins_raw)
  );

  assign s = pins_raw;

  bmesc_div #(
    .WIDTH    (8)
  ) u_div (
    .clk      (clk),
    .rst      (rst),
    .run_i    (running),
    .period_i (q.period),
    .tick_o   (sw_tick)
  );

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Status word
  always_comb begin
    status                = '0;
    status.init_done      = q.init_done;
    status.fault          = fault;
    status.power_save     = power_save;
    status.sync_present   = q.sync_pres;
    status.nonsync_active = (q.ns_cnt != 3'h0);
    status.sout           = q.sout;
    status.vstrap         = q.vstrap;
    status.fstrap         = q.fstrap;
    status.op             = q.op;
    status.fsm            = {1'b0, q.fsm};
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n          = q;
    running    = (q.fsm == FS_RAMP) || (q.fsm == FS_RUN);
    fault      = s.thermal_fault | s.overvoltage_fault;
    en_ok      = s.en_pin & ~fault;
    req        = wb_cyc_i & wb_stb_i & ~q.ack;

    // Sync clock detection on the mode pin
    n.mode_d = s.mode_pin;
    if (s.mode_pin != q.mode_d) begin
      n.gap       = 8'h00;
      n.sync_pres = (q.gap < SYNC_GAP_CYC);
    end else if (q.gap != SYNC_GAP_CYC) begin
      n.gap = q.gap + 8'h01;
    end else begin
      n.sync_pres = 1'b0;
    end

    // Mode selection
    forced     = q.forced_pwm_select_bit | s.mode_pin | q.sync_pres;
    power_save = ~forced | (q.fsm == FS_RAMP);

    // Power-up sequence and enable gating
    case (q.fsm)
      FS_LOCKOUT: begin
        n.init_done = 1'b0;
        n.timer     = 24'(REF_CYC);
        n.fsm       = FS_REF;
      end
      FS_REF: begin
        if (q.timer <= 24'h00_0001) begin
          n.timer = 24'(STRAP_CYC);
          n.fsm   = FS_STRAP;
        end else begin
          n.timer = q.timer - 24'h00_0001;
        end
      end
      FS_STRAP: begin
        if (q.timer <= 24'h00_0001) begin
          n.vstrap = s.voltage_strap_pin;
          n.fstrap = s.frequency_strap_pin;
          n.sout   = s.sync_out_strap;
          case (s.frequency_strap_pin)
            STRAP_GND:     n.period = PER_B;
            STRAP_RES_GND: n.period = PER_A;
            STRAP_RES_VIN: n.period = PER_D;
            STRAP_VIN:     n.period = PER_C;
            default:       n.period = PER_RST;
          endcase
          n.fsm = FS_LOAD;
        end else begin
          n.timer = q.timer - 24'h00_0001;
        end
      end
      FS_LOAD: begin
        n.forced_pwm_select_bit = CA_FORCED_PULSE_WIDTH_OPERATION_RST;
        n.nonsync_en            = CA_NONSYNC_RST;
        n.standalone            = CC_SINGLE_RST;
        n.init_done             = 1'b1;
        n.fsm                   = FS_IDLE;
      end
      FS_IDLE: begin
        if (en_ok) begin
          n.timer = 24'(EN_DELAY_CYC);
          n.fsm   = FS_DELAY;
        end
      end
      FS_DELAY: begin
        if (!en_ok) begin
          n.fsm = FS_IDLE;
        end else if (q.timer <= 24'h00_0001) begin
          n.timer = 24'(RAMP_CYCLES);
          n.fsm   = FS_RAMP;
        end else begin
          n.timer = q.timer - 24'h00_0001;
        end
      end
      FS_RAMP: begin
        if (!en_ok) begin
          n.fsm = FS_IDLE;
        end else if (q.timer <= 24'h00_0001) begin
          n.fsm = FS_RUN;
        end else begin
          n.timer = q.timer - 24'h00_0001;
        end
      end
      FS_RUN: begin
        if (!en_ok) begin
          n.fsm = FS_IDLE;
        end
      end
      default: begin
        n.fsm = FS_LOCKOUT;
      end
    endcase

    // Lockout restarts the sequence from any state
    if (s.input_undervoltage_lockout) begin
      n.fsm       = FS_LOCKOUT;
      n.init_done = 1'b0;
    end

    // Enable open-drain pulldown
    n.pull = ~n.init_done | (fault & ~q.standalone);

    // Operating kind
    if (!running) begin
      n.op = OP_OFF;
    end else if (!power_save) begin
      n.op = OP_CCM;
    end else if (s.load_level == LOAD_VERY_LOW) begin
      n.op = OP_PFM;
    end else if (s.load_level == LOAD_LOW) begin
      n.op = OP_DCM;
    end else begin
      n.op = OP_CCM;
    end

    // Non-synchronous phase after a load release
    n.rel_d = s.load_release;
    if (!running) begin
      n.ns_cnt = 3'h0;
    end else if (q.nonsync_en && s.load_release && !q.rel_d) begin
      n.ns_cnt = NONSYNC_CYCLES;
    end else if (sw_tick && q.ns_cnt != 3'h0) begin
      n.ns_cnt = q.ns_cnt - 3'h1;
    end

    // Power switch gates
    n.hs = running & sw_tick & ((n.op != OP_PFM) | s.pfm_demand);
    n.ls = running & ~n.hs & (n.ns_cnt == 3'h0)
         & ((n.op == OP_CCM) | ~s.zero_cross);

    // Wishbone slave
    n.ack = req;
    if (req) begin
      n.rdat = 32'h0000_0000;
      if (q.init_done) begin
        if (wb_we_i && wb_sel_i[0]) begin
          case (wb_adr_i)
            ADR_CTRL_A: begin
              n.forced_pwm_select_bit = wb_dat_i[CA_FORCED_PULSE_WIDTH_OPERATION_BIT];
              n.nonsync_en            = wb_dat_i[CA_NONSYNC_BIT];
            end
            ADR_CTRL_C: begin
              n.standalone = wb_dat_i[CC_SINGLE_BIT];
            end
            default: begin
              n.rdat = 32'h0000_0000;
            end
          endcase
        end else if (!wb_we_i) begin
          case (wb_adr_i)
            ADR_CTRL_A: begin
              n.rdat[CA_FORCED_PULSE_WIDTH_OPERATION_BIT]    = q.forced_pwm_select_bit;
              n.rdat[CA_NONSYNC_BIT] = q.nonsync_en;
            end
            ADR_CTRL_C: begin
              n.rdat[CC_SINGLE_BIT] = q.standalone;
            end
            ADR_STATUS: begin
              n.rdat = status;
            end
            default: begin
              n.rdat = 32'h0000_0000;
            end
          endcase
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= STATE_RST;
    end else begin
      q <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign wb_dat_o    = q.rdat;
  assign wb_ack_o    = q.ack;
  assign en_pin_o    = 1'b0;
  assign en_pin_oe   = q.pull;
  assign hs_gate_o   = q.hs;
  assign ls_gate_o   = q.ls;
  assign op_mode_o   = q.op;
  assign reg_if_en_o = q.init_done;
  assign ramp_o      = (q.fsm == FS_RAMP);

endmodule : bmesc_top

// ### verification/bmesc_peer.sv
/* Partner model: the external enable driver and one stacked peer on the shared enable line.
   Assumes an external pull-up on the line; a low from any party wins. */
`timescale 1ns/10ps
module bmesc_peer #(
  parameter int INIT_CYC = 8
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic peer_fault_i,
  input  wire logic ext_en_i,
  input  wire logic dut_oe_i,
  output logic      en_line_o
);
  int unsigned init_cnt_q;
  logic        peer_oe;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Peer initialisation time, counted from reset release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      init_cnt_q <= '0;
    end else if (init_cnt_q < INIT_CYC) begin
      init_cnt_q <= init_cnt_q + 1;
    end
  end

  assign peer_oe   = (init_cnt_q < INIT_CYC) | peer_fault_i;
  // Open-drain wired-AND of both pulldowns and the driver
  assign en_line_o = !(dut_oe_i | peer_oe | !ext_en_i);
endmodule : bmesc_peer

// ### verification/bmesc_assertions.sv
/* Checker of the port behaviour of bmesc_top.
   Assumes one clock domain; attached by the bind at the foot of this file. */
`timescale 1ns/10ps
module bmesc_assertions #(
  parameter int RAMP_CYCLES = 50
) (
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_we_i,
  input wire logic [7:0]                wb_adr_i,
  input wire logic [3:0]                wb_sel_i,
  input wire logic [31:0]               wb_dat_i,
  input wire logic [31:0]               wb_dat_o,
  input wire logic                      wb_ack_o,
  input wire bmesc_pkg::bmesc_pins_type pins_i,
  input wire logic                      en_pin_o,
  input wire logic                      en_pin_oe,
  input wire logic                      hs_gate_o,
  input wire logic                      ls_gate_o,
  input wire bmesc_pkg::bmesc_op_type   op_mode_o,
  input wire logic                      reg_if_en_o,
  input wire logic                      ramp_o
);
  import bmesc_pkg::*;
  logic sa_q;
  logic flt;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Shadow of the standalone bit, cleared at every init
  assign flt = pins_i.thermal_fault | pins_i.overvoltage_fault;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sa_q <= 1'h0;
    end else if (!reg_if_en_o) begin
      sa_q <= 1'h0;
    end else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTRL_C) begin
      sa_q <= wb_dat_i[0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_ack_one_shot: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_on_request: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked in one cycle");
  a_init_pulls_en: assert property (!reg_if_en_o |-> en_pin_oe)
    else $error("enable not pulled during init");
  a_ready_release: assert property ((reg_if_en_o && !flt) [*4] |-> !en_pin_oe)
    else $error("enable held after init without fault");
  a_fault_pulls_en: assert property ((flt && !sa_q) [*4] |-> en_pin_oe)
    else $error("fault did not pull enable");
  a_standalone_quiet: assert property ((reg_if_en_o && sa_q) [*4] |-> !en_pin_oe)
    else $error("standalone still pulls enable");
  a_enable_low_idle: assert property ((!pins_i.en_pin) [*5] |->
    op_mode_o == OP_OFF && !hs_gate_o && !ls_gate_o && !ramp_o)
    else $error("converter active with enable low");
  a_forced_ccm: assert property ((pins_i.mode_pin && !ramp_o && op_mode_o != OP_OFF) [*5]
    |-> op_mode_o == OP_CCM)
    else $error("mode pin high but not continuous");
  a_ramp_skip_ok: assert property ((ramp_o && pins_i.load_level == LOAD_VERY_LOW) [*5]
    |-> op_mode_o == OP_PFM)
    else $error("ramp not in pulse skip at very low load");

  c_ramp: cover property ($rose(ramp_o));
  c_fault: cover property ($rose(en_pin_oe) && reg_if_en_o);
  c_write: cover property (wb_ack_o && wb_we_i);
endmodule : bmesc_assertions

bind bmesc_top bmesc_assertions #(.RAMP_CYCLES(RAMP_CYCLES)) bmesc_assertions_inst (
  .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pins_i(pins_i), .en_pin_o(en_pin_o), .en_pin_oe(en_pin_oe),
  .hs_gate_o(hs_gate_o), .ls_gate_o(ls_gate_o), .op_mode_o(op_mode_o),
  .reg_if_en_o(reg_if_en_o), .ramp_o(ramp_o));

// ### verification/testbench.sv
/* Self-checking testbench of bmesc_top with a Wishbone master and a peer on the enable line.
   Assumes the package, design files, peer model and checker are compiled first. */
`timescale 1ns/10ps
module testbench;
  import bmesc_pkg::*;
  localparam int M_HS = 0, M_LS = 1, M_EN = 2, M_RDY = 3, M_RAMP = 4;
  logic           clk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [7:0]     adr = 8'h00;
  logic [3:0]     sel = 4'h0;
  logic [31:0]    wdat = 32'h0000_0000, rdat, got;
  logic           ack, en_oe, hs, ls, reg_if_en, ramp, en_line;
  logic           ext_en = 1'h1, peer_fault = 1'h0;
  bmesc_pins_type pins = '0, pins_w;
  bmesc_op_type   op, exp_op [4] = '{OP_PFM, OP_DCM, OP_CCM, OP_CCM};
  logic [4:0]     mon;
  int             err_count = 0, compares = 0;

  bmesc_top #(.RAMP_CYCLES(50)) bmesc_top_inst (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pins_i(pins_w), .en_pin_o(), .en_pin_oe(en_oe),
    .hs_gate_o(hs), .ls_gate_o(ls), .op_mode_o(op), .reg_if_en_o(reg_if_en), .ramp_o(ramp));
  bmesc_peer #(.INIT_CYC(900)) bmesc_peer_inst (.clk(clk), .rst(rst),
    .peer_fault_i(peer_fault), .ext_en_i(ext_en), .dut_oe_i(en_oe), .en_line_o(en_line));

  always #4 clk = ~clk;
  always_comb begin
    pins_w        = pins;
    pins_w.en_pin = en_line;
  end
  assign mon = {ramp, reg_if_en, en_line, ls, hs};

  ////////////////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'h1;
    stb  <= 1'h1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 50);
    got = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (n >= 50) err_count++;
  endtask : wb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    wb(1'h0, a, 32'h0000_0000);
    chk(got & mask, exp);
  endtask : rd_chk

  task automatic wait_lvl(input int idx, input logic lvl, input int lim);
    int n;
    n = 0;
    while (mon[idx] !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(32'(mon[idx]), 32'(lvl));
  endtask : wait_lvl

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    int n;
    int k;
    pins.input_undervoltage_lockout = 1'h1;
    pins.voltage_strap_pin = 2'h2;
    pins.frequency_strap_pin = 2'h1;
    pins.sync_out_strap = 1'h1;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    rd_chk(ADR_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
    chk({31'h0, en_oe}, 32'h0000_0001);
    pins.input_undervoltage_lockout <= 1'h0;
    wait_lvl(M_RDY, 1'h1, 1000);
    repeat (3) @(posedge clk);
    chk({31'h0, en_oe}, 32'h0000_0000);
    rd_chk(ADR_STATUS, 32'h0000_03E3, 32'h0000_01A1);
    rd_chk(ADR_CTRL_C, 32'hFFFF_FFFF, 32'h0000_0000);
    wb(1'h1, 8'h0C, 32'hFFFF_FFFF);
    rd_chk(8'h0C, 32'hFFFF_FFFF, 32'h0000_0000);
    wb(1'h1, ADR_CTRL_A, 32'h0000_0001);
    rd_chk(ADR_CTRL_A, 32'h0000_0003, 32'h0000_0001);
    chk({31'h0, ramp | en_line}, 32'h0000_0000);
    $display("test init done");
    pins.load_level <= 2'h0;
    wait_lvl(M_EN, 1'h1, 1000);
    wait_lvl(M_RAMP, 1'h1, 1300);
    repeat (6) @(posedge clk);
    chk(32'(op), 32'(OP_PFM));
    wait_lvl(M_RAMP, 1'h0, 100);
    repeat (6) @(posedge clk);
    chk(32'(op), 32'(OP_CCM));
    for (int i = 0; i < 4; i++) begin
      pins.mode_pin <= i[1];
      wb(1'h1, ADR_CTRL_A, {31'h0, i[0]});
      repeat (8) @(posedge clk);
      rd_chk(ADR_STATUS, 32'h0000_0004, {29'h0, i == 0, 2'h0});
    end
    pins.mode_pin <= 1'h0;
    wb(1'h1, ADR_CTRL_A, 32'h0000_0000);
    repeat (2) @(posedge clk);
    rd_chk(ADR_STATUS, 32'h0000_0008, 32'h0000_0008);
    repeat (130) @(posedge clk);
    for (int l = 0; l < 4; l++) begin
      pins.load_level <= 2'(l);
      repeat (8) @(posedge clk);
      chk(32'(op), 32'(exp_op[l]));
    end
    pins.mode_pin <= 1'h1;
    wb(1'h1, ADR_CTRL_A, 32'h0000_0003);
    $display("test modes done");
    pins.load_release <= 1'h1;
    n = 0;
    k = 0;
    while ((k < 4 || ls !== 1'h1) && k < 1000) begin
      @(posedge clk);
      k++;
      if (k == 5) pins.load_release <= 1'h0;
      if (hs === 1'h1 && k > 4) n++;
    end
    chk(32'(n), 32'(NONSYNC_CYCLES));
    pins.thermal_fault <= 1'h1;
    wait_lvl(M_EN, 1'h0, 10);
    repeat (6) @(posedge clk);
    chk(32'(op), 32'(OP_OFF));
    rd_chk(ADR_STATUS, 32'h0000_0002, 32'h0000_0002);
    wb(1'h1, ADR_CTRL_C, 32'h0000_0001);
    repeat (6) @(posedge clk);
    chk({31'h0, en_oe}, 32'h0000_0000);
    pins.thermal_fault <= 1'h0;
    wb(1'h1, ADR_CTRL_C, 32'h0000_0000);
    wait_lvl(M_RAMP, 1'h1, 1300);
    peer_fault <= 1'h1;
    repeat (6) @(posedge clk);
    chk(32'(op), 32'(OP_OFF));
    peer_fault <= 1'h0;
    $display("test faults done");
    pins.input_undervoltage_lockout <= 1'h1;
    wait_lvl(M_RDY, 1'h0, 10);
    repeat (2) @(posedge clk);
    chk({31'h0, en_oe}, 32'h0000_0001);
    pins.input_undervoltage_lockout <= 1'h0;
    wait_lvl(M_RDY, 1'h1, 1000);
    rd_chk(ADR_CTRL_A, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("test lockout done");
    end_sim();
  end

  initial begin
    repeat (50000) @(posedge clk);
    err_count++;
    end_sim();
  end
endmodule : testbench
